//--- rtc_pin_block.sv
// Supervisor reset, wave/interrupt pins and serial pin engine of the RTC
`timescale 1ns/10ps
module rtc_pin_block
  import rtc_pin_pkg::*;
#(
  parameter logic [DLY_W-1:0] RST_DELAY_CYCLES = DLY_W'(RST_DELAY_CYC),
  parameter logic [DLY_W-1:0] OSC_START_CYCLES = DLY_W'(OSC_START_CYC)
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              power_ok,
  input  wire logic              osc_disabled,
  input  wire logic              osc_clk,
  input  wire logic              rst_pin_in,
  output logic                   rst_pin_out,
  output logic                   rst_pin_oe,
  input  wire logic              wave_enable,
  input  wire logic [1:0]        wave_rate,
  input  wire logic              irq_enable,
  input  wire logic              irq_request,
  output logic                   wave_or_irq_out,
  output logic                   wave_or_irq_oe,
  output logic                   wave_out,
  output logic                   wave_oe,
  output logic                   irq_out_n,
  output logic                   irq_oe,
  input  wire logic              three_wire,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              ce,
  input  wire logic              din,
  output logic                   dout_out,
  output logic                   dout_oe,
  input  wire logic              io_in,
  output logic                   io_out,
  output logic                   io_oe,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [7:0]             wr_data,
  output logic                   wr_strobe,
  input  wire logic [7:0]        rd_data
);

  // Two-stage synchronisers for every pin input
  logic [SY_N-1:0] raw;
  logic [SY_N-1:0] meta_reg;
  logic [SY_N-1:0] sync_reg;

  assign raw = {three_wire, io_in, din, ce, cs_n, sclk, osc_clk, rst_pin_in, power_ok};

  genvar gi;
  generate
    for (gi = 0; gi < SY_N; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!resetn) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= raw[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  // Oscillator tick detection and divider
  logic              osc_q_reg, osc_q_next;
  logic [DIV_W-1:0]  div_reg, div_next;
  logic              osc_tick;

  always_comb begin
    osc_q_next = sync_reg[SY_OSC];
    osc_tick   = sync_reg[SY_OSC] & ~osc_q_reg;
    div_next   = osc_tick ? div_reg + DIV_W'(1) : div_reg;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      osc_q_reg <= 1'b0;
      div_reg   <= '0;
    end else begin
      osc_q_reg <= osc_q_next;
      div_reg   <= div_next;
    end
  end

  // Supervisor: power fail, release delay, pushbutton
  sup_state_t        sup_reg, sup_next;
  logic [DLY_W-1:0]  dly_reg, dly_next;
  logic [DB_W-1:0]   db_reg, db_next;
  logic              rst_oe_reg, rst_oe_next;
  logic              access_ok;
  logic [DLY_W-1:0]  hold_len;

  always_comb begin
    hold_len = osc_disabled ? RST_DELAY_CYCLES + OSC_START_CYCLES
                            : RST_DELAY_CYCLES;
    sup_next = sup_reg;
    dly_next = dly_reg;
    db_next  = db_reg;
    if (!sync_reg[SY_PWR]) begin
      sup_next = SUP_FAIL;
    end else begin
      unique case (sup_reg)
        SUP_FAIL: begin
          sup_next = SUP_HOLD;
          dly_next = hold_len;
        end
        SUP_HOLD: begin
          if (dly_reg <= DLY_W'(1)) begin
            sup_next = SUP_WAIT_REL;
          end else begin
            dly_next = dly_reg - DLY_W'(1);
          end
        end
        SUP_WAIT_REL: begin
          // Pin must read high again before the button is re-armed
          if (sync_reg[SY_RSTIN]) begin
            sup_next = SUP_RUN;
          end
        end
        SUP_RUN: begin
          if (!sync_reg[SY_RSTIN]) begin
            sup_next = SUP_DEBOUNCE;
            db_next  = '0;
          end
        end
        SUP_DEBOUNCE: begin
          if (sync_reg[SY_RSTIN]) begin
            sup_next = SUP_RUN;
          end else if (db_reg == DEBOUNCE_TICKS) begin
            sup_next = SUP_HOLD;
            dly_next = hold_len;
          end else if (osc_tick) begin
            db_next = db_reg + DB_W'(1);
          end
        end
      endcase
    end
    rst_oe_next = (sup_next == SUP_FAIL) || (sup_next == SUP_HOLD);
  end

  assign access_ok = (sup_reg == SUP_RUN) || (sup_reg == SUP_DEBOUNCE);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sup_reg    <= SUP_FAIL;
      dly_reg    <= '0;
      db_reg     <= '0;
      rst_oe_reg <= 1'b1;
    end else begin
      sup_reg    <= sup_next;
      dly_reg    <= dly_next;
      db_reg     <= db_next;
      rst_oe_reg <= rst_oe_next;
    end
  end

  // Square wave and interrupt pins, independent of supply state
  logic wave_lvl;
  logic irq_act;
  logic wave_oe_reg, wave_oe_next;
  logic shared_oe_reg, shared_oe_next;
  logic irq_oe_reg, irq_oe_next;

  always_comb begin
    unique case (wave_rate)
      RATE_32K: wave_lvl = osc_q_reg;
      RATE_8K:  wave_lvl = div_reg[DIV_BIT_8K];
      RATE_4K:  wave_lvl = div_reg[DIV_BIT_4K];
      RATE_1HZ: wave_lvl = div_reg[DIV_BIT_1HZ];
    endcase
    irq_act        = irq_enable & irq_request;
    wave_oe_next   = wave_enable & ~wave_lvl;
    shared_oe_next = wave_enable ? ~wave_lvl : irq_act;
    irq_oe_next    = irq_act;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wave_oe_reg   <= 1'b0;
      shared_oe_reg <= 1'b0;
      irq_oe_reg    <= 1'b0;
    end else begin
      wave_oe_reg   <= wave_oe_next;
      shared_oe_reg <= shared_oe_next;
      irq_oe_reg    <= irq_oe_next;
    end
  end

  // Serial engine: sample on falling SCLK, shift out on rising SCLK
  ser_state_t        ser_reg, ser_next;
  logic              sclk_q_reg, sclk_q_next;
  logic [2:0]        bit_reg, bit_next;
  logic [7:0]        in_sh_reg, in_sh_next;
  logic [7:0]        out_sh_reg, out_sh_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0]        wdat_reg, wdat_next;
  logic              wstb_reg, wstb_next;
  logic              sel;
  logic              sdi;
  logic              s_rise;
  logic              s_fall;
  logic [7:0]        shifted;

  always_comb begin
    sel     = sync_reg[SY_3W] ? sync_reg[SY_CE] : ~sync_reg[SY_CSN];
    sdi     = sync_reg[SY_3W] ? sync_reg[SY_IOIN] : sync_reg[SY_DIN];
    s_rise  = sync_reg[SY_SCLK] & ~sclk_q_reg;
    s_fall  = ~sync_reg[SY_SCLK] & sclk_q_reg;
    shifted = {in_sh_reg[6:0], sdi};
    sclk_q_next = sync_reg[SY_SCLK];
    ser_next    = ser_reg;
    bit_next    = bit_reg;
    in_sh_next  = in_sh_reg;
    out_sh_next = out_sh_reg;
    addr_next   = addr_reg;
    wdat_next   = wdat_reg;
    wstb_next   = 1'b0;
    if (!sel || !access_ok) begin
      ser_next = SER_IDLE;
      bit_next = '0;
    end else begin
      unique case (ser_reg)
        SER_IDLE: ser_next = SER_ADDR;
        SER_ADDR: begin
          if (s_fall) begin
            in_sh_next = shifted;
            bit_next   = bit_reg + 3'h1;
            if (bit_reg == LAST_BIT) begin
              addr_next = shifted[ADDR_W-1:0];
              ser_next  = shifted[WR_FLAG_BIT] ? SER_WRITE : SER_READ;
            end
          end
        end
        SER_WRITE: begin
          if (s_fall) begin
            in_sh_next = shifted;
            bit_next   = bit_reg + 3'h1;
            if (bit_reg == LAST_BIT) begin
              wdat_next = shifted;
              wstb_next = 1'b1;
            end
          end
          if (wstb_reg) begin
            addr_next = addr_reg + ADDR_W'(1);
          end
        end
        SER_READ: begin
          if (s_rise) begin
            out_sh_next = (bit_reg == 3'h0) ? rd_data
                                            : {out_sh_reg[6:0], 1'b0};
          end
          if (s_fall) begin
            bit_next = bit_reg + 3'h1;
            if (bit_reg == LAST_BIT) begin
              addr_next = addr_reg + ADDR_W'(1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ser_reg    <= SER_IDLE;
      sclk_q_reg <= 1'b0;
      bit_reg    <= '0;
      in_sh_reg  <= '0;
      out_sh_reg <= '0;
      addr_reg   <= '0;
      wdat_reg   <= '0;
      wstb_reg   <= 1'b0;
    end else begin
      ser_reg    <= ser_next;
      sclk_q_reg <= sclk_q_next;
      bit_reg    <= bit_next;
      in_sh_reg  <= in_sh_next;
      out_sh_reg <= out_sh_next;
      addr_reg   <= addr_next;
      wdat_reg   <= wdat_next;
      wstb_reg   <= wstb_next;
    end
  end

  // Pin drivers, all from flip-flops
  logic rd_mode;
  logic dout_oe_reg, io_oe_reg;

  assign rd_mode = (ser_reg == SER_READ);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dout_oe_reg <= 1'b0;
      io_oe_reg   <= 1'b0;
    end else begin
      dout_oe_reg <= rd_mode & ~sync_reg[SY_3W];
      io_oe_reg   <= rd_mode & sync_reg[SY_3W];
    end
  end

  assign rst_pin_out     = 1'b0;
  assign rst_pin_oe      = rst_oe_reg;
  assign wave_or_irq_out = 1'b0;
  assign wave_or_irq_oe  = shared_oe_reg;
  assign wave_out        = 1'b0;
  assign wave_oe         = wave_oe_reg;
  assign irq_out_n       = 1'b0;
  assign irq_oe          = irq_oe_reg;
  assign dout_out        = out_sh_reg[7];
  assign dout_oe         = dout_oe_reg;
  assign io_out          = out_sh_reg[7];
  assign io_oe           = io_oe_reg;
  assign reg_addr        = addr_reg;
  assign wr_data         = wdat_reg;
  assign wr_strobe       = wstb_reg;

endmodule

//--- rtc_pin_pkg.sv
// Constants and types for the RTC supervisor, wave and serial pin block
// Notes on behaviour
// - Reset pin is driven low while the primary supply is below threshold.
// - After supply recovers, reset stays low for the release delay, then floats.
// - A pushbutton low on reset is debounced, then answered by a reset pulse.
// - Oscillator disabled lengthens the release delay by the oscillator startup time.
// - Square wave appears on the shared pin only while wave enable is one.
// - Wave rate is one of 32.768kHz, 8.192kHz, 4.096kHz or 1Hz.
// - Dedicated interrupt pin goes low only when interrupt output is enabled.
// - Wave and interrupt outputs keep working on primary or backup supply.
// - Serial data output is driven push-pull only during read mode.
// - Three-wire variant shares one push-pull data pin for both directions.
// - Serial access is blocked after supply recovery until reset goes high.
package rtc_pin_pkg;

  localparam int CLK_HZ        = 10_000_000;
  localparam int CYC_PER_MS    = CLK_HZ / 1000;
  localparam int RST_DELAY_MS  = 250;
  localparam int OSC_START_MS  = 1000;
  localparam int RST_DELAY_CYC = RST_DELAY_MS * CYC_PER_MS;
  localparam int OSC_START_CYC = OSC_START_MS * CYC_PER_MS;
  localparam int DLY_W         = 24;

  localparam int          DB_W           = 9;
  localparam logic [8:0]  DEBOUNCE_TICKS = 9'h148;

  localparam int          DIV_W       = 15;
  localparam logic [1:0]  RATE_32K    = 2'h0;
  localparam logic [1:0]  RATE_8K     = 2'h1;
  localparam logic [1:0]  RATE_4K     = 2'h2;
  localparam logic [1:0]  RATE_1HZ    = 2'h3;
  localparam int          DIV_BIT_8K  = 1;
  localparam int          DIV_BIT_4K  = 2;
  localparam int          DIV_BIT_1HZ = 14;

  localparam int SY_PWR   = 0;
  localparam int SY_RSTIN = 1;
  localparam int SY_OSC   = 2;
  localparam int SY_SCLK  = 3;
  localparam int SY_CSN   = 4;
  localparam int SY_CE    = 5;
  localparam int SY_DIN   = 6;
  localparam int SY_IOIN  = 7;
  localparam int SY_3W    = 8;
  localparam int SY_N     = 9;

  localparam int          ADDR_W      = 7;
  localparam int          WR_FLAG_BIT = 7;
  localparam logic [2:0]  LAST_BIT    = 3'h7;

  typedef enum logic [2:0] {
    SUP_FAIL, SUP_HOLD, SUP_RUN, SUP_DEBOUNCE, SUP_WAIT_REL
  } sup_state_t;

  typedef enum logic [1:0] {
    SER_IDLE, SER_ADDR, SER_WRITE, SER_READ
  } ser_state_t;

endpackage

//--- rtc_pin_block_properties.sv
// Checker for the reset, interrupt (dedicated and shared) and serial pins of rtc_pin_block
`timescale 1ns/10ps
module rtc_pin_block_properties
  import rtc_pin_pkg::*;
#(
  parameter logic [DLY_W-1:0] RST_DELAY_CYCLES = DLY_W'(RST_DELAY_CYC),
  parameter logic [DLY_W-1:0] OSC_START_CYCLES = DLY_W'(OSC_START_CYC)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic power_ok,
  input wire logic osc_disabled,
  input wire logic rst_pin_oe,
  input wire logic wave_enable,
  input wire logic irq_enable,
  input wire logic irq_request,
  input wire logic wave_or_irq_oe,
  input wire logic irq_oe,
  input wire logic three_wire,
  input wire logic cs_n,
  input wire logic ce,
  input wire logic dout_oe,
  input wire logic io_oe,
  input wire logic wr_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [DLY_W-1:0] hi_reg;
  logic [DLY_W-1:0] hi_next;
  logic [DLY_W-1:0] hold;
  // Cycles the reset pin has been held with supply good
  always_comb begin
    hi_next = (rst_pin_oe && power_ok) ? hi_reg + 1'b1 : '0;
    hold = RST_DELAY_CYCLES + (osc_disabled ? OSC_START_CYCLES : '0);
  end
  always_ff @(posedge clk) begin
    if (!resetn) hi_reg <= '0;
    else hi_reg <= hi_next;
  end
  a_fail_drives_reset: assert property (!power_ok [*3] |=> rst_pin_oe)
    else $error("reset pin not driven after supply loss");
  a_release_delay_len: assert property ($fell(rst_pin_oe) |->
    hi_reg + 1'b1 >= hold && hi_reg <= hold + 6)
    else $error("reset released after wrong delay");
  a_shared_pin_irq: assert property (!wave_enable && $past(!wave_enable) |->
    wave_or_irq_oe == $past(irq_enable && irq_request))
    else $error("shared pin does not follow interrupt");
  a_irq_needs_enable: assert property (irq_oe |-> $past(irq_enable && irq_request))
    else $error("interrupt pin low without enable");
  a_irq_any_supply: assert property (irq_enable && irq_request |=> irq_oe)
    else $error("interrupt pin missing");
  a_dout_needs_select: assert property ((cs_n || three_wire) [*5] |-> !dout_oe)
    else $error("data out driven while not selected");
  a_io_needs_enable: assert property ((!ce || !three_wire) [*5] |-> !io_oe)
    else $error("data pin driven while not enabled");
  a_access_blocked: assert property (!power_ok [*6] |->
    !wr_strobe && !dout_oe && !io_oe)
    else $error("serial access during power fail");
  a_strobe_one_cycle: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  cover property ($fell(rst_pin_oe));
  cover property (wr_strobe);
  cover property (dout_oe);
  cover property (io_oe);
endmodule
bind rtc_pin_block rtc_pin_block_properties #(.RST_DELAY_CYCLES(RST_DELAY_CYCLES),
  .OSC_START_CYCLES(OSC_START_CYCLES)) u_props (.clk, .resetn, .power_ok, .osc_disabled,
  .rst_pin_oe, .wave_enable, .irq_enable, .irq_request, .wave_or_irq_oe, .irq_oe,
  .three_wire, .cs_n, .ce, .dout_oe, .io_oe, .wr_strobe);

//--- rtc_host_model.sv
// Serial bus master model driving the block in mode 1 timing
`timescale 1ns/10ps
module rtc_host_model (
  input  wire logic three_wire,
  input  wire logic dout_out,
  input  wire logic io_out,
  input  wire logic io_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      ce,
  output logic      din,
  output logic      io_in
);
  logic drv;
  assign din = drv;
  assign io_in = io_oe ? io_out : drv;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    ce = 1'b0;
    drv = 1'b0;
  end
  // Address byte then two data bytes, 800 ns per bit
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
    logic [23:0] sh;
    sh = {a, d};
    cs_n = three_wire;
    ce = three_wire;
    #400;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b1;
      drv = sh[i];
      #400;
      sh[i] = three_wire ? io_in : dout_out;
      sclk = 1'b0;
      #400;
    end
    r = sh[15:0];
    cs_n = 1'b1;
    ce = 1'b0;
    // Released line shows no stale value
    drv = ~drv;
  endtask
endmodule

//--- rtc_pin_block_test.sv
// Self-checking testbench for rtc_pin_block
`timescale 1ns/10ps
module rtc_pin_block_test;
  import rtc_pin_pkg::*;
  localparam logic [DLY_W-1:0] RST_D = 24'h14;
  localparam logic [DLY_W-1:0] OSC_D = 24'h0a;
  logic clk, resetn, power_ok, osc_disabled, osc_clk, button, rst_pin_in;
  logic wave_enable, irq_enable, irq_request, three_wire;
  logic [1:0] wave_rate;
  logic rst_pin_out, rst_pin_oe, wave_or_irq_out, wave_or_irq_oe, wave_out, wave_oe;
  logic irq_out_n, irq_oe, sclk, cs_n, ce, din, dout_out, dout_oe, io_in, io_out, io_oe;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] wr_data, rd_data, s_addr, s_data;
  logic wr_strobe;
  logic [15:0] rd;
  int failures, checks_done, strobes;
  // Reset pin has a pull-up; button or own drive pull it low
  assign rst_pin_in = !(rst_pin_oe || button);
  assign rd_data = {1'b0, reg_addr} ^ 8'h3c;
  rtc_pin_block #(.RST_DELAY_CYCLES(RST_D), .OSC_START_CYCLES(OSC_D)) dut (.clk, .resetn,
    .power_ok, .osc_disabled, .osc_clk, .rst_pin_in, .rst_pin_out, .rst_pin_oe, .wave_enable,
    .wave_rate, .irq_enable, .irq_request, .wave_or_irq_out, .wave_or_irq_oe, .wave_out,
    .wave_oe, .irq_out_n, .irq_oe, .three_wire, .sclk, .cs_n, .ce, .din, .dout_out, .dout_oe,
    .io_in, .io_out, .io_oe, .reg_addr, .wr_data, .wr_strobe, .rd_data);
  rtc_host_model host (.three_wire, .dout_out, .io_out, .io_oe, .sclk, .cs_n, .ce, .din,
    .io_in);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    osc_clk = 1'b0;
    forever #800 osc_clk = ~osc_clk;
  end
  always @(posedge clk) begin
    if (!resetn) begin
      strobes <= 0;
    end else if (wr_strobe === 1'b1) begin
      strobes <= strobes + 1;
      s_addr <= {1'b0, reg_addr};
      s_data <= wr_data;
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task power_cycle(input logic osc, input int exp);
    int n;
    osc_disabled = osc;
    power_ok = 1'b0;
    tick(5);
    check(rst_pin_oe, 1);
    power_ok = 1'b1;
    n = 0;
    while (rst_pin_oe === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check(n >= exp && n <= exp + 6, 1);
    tick(6);
    $display("power cycle done");
  endtask
  task button_press;
    int n;
    osc_disabled = 1'b0;
    button = 1'b1;
    tick(200);
    button = 1'b0;
    tick(5);
    check(rst_pin_oe, 0);
    button = 1'b1;
    n = 0;
    while (rst_pin_oe !== 1'b1 && n < 8000) begin
      tick(1);
      n++;
    end
    check(n >= 5200 && n < 8000, 1);
    button = 1'b0;
    n = 0;
    while (rst_pin_oe === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check(n + 2 >= RST_D && n <= RST_D + 6, 1);
    tick(10);
    $display("button test done");
  endtask
  task wave_rates;
    int n;
    int m;
    int exp;
    logic p;
    logic q;
    irq_enable = 1'b1;
    irq_request = 1'b1;
    for (int r = 0; r < 5; r++) begin
      // Pass 4 repeats the fastest rate on backup supply
      wave_enable = 1'b1;
      wave_rate = r[1:0];
      power_ok = (r != 4);
      exp = (r == 1) ? 100 : (r == 2) ? 50 : (r == 3) ? 0 : 400;
      tick(40);
      n = 0;
      m = 0;
      p = wave_or_irq_oe;
      q = wave_oe;
      repeat (3200) begin
        tick(1);
        if (wave_or_irq_oe !== p) n++;
        if (wave_oe !== q) m++;
        p = wave_or_irq_oe;
        q = wave_oe;
      end
      check(n + 2 >= exp && n <= exp + 2, 1);
      check(m + 2 >= exp && m <= exp + 2, 1);
      check(irq_oe, 1);
    end
    wave_enable = 1'b0;
    tick(3);
    check(wave_or_irq_oe, 1);
    irq_request = 1'b0;
    tick(3);
    check({wave_or_irq_oe, irq_oe, wave_oe}, 0);
    check({rst_pin_out, wave_or_irq_out, wave_out, irq_out_n}, 0);
    power_cycle(1'b0, RST_D);
    $display("wave test done");
  endtask
  task serial(input logic tw);
    int base;
    logic [7:0] wd;
    three_wire = tw;
    wd = tw ? 8'hc3 : 8'h5a;
    tick(5);
    base = strobes;
    host.xfer(8'h85, {8'ha5, wd}, rd);
    tick(6);
    check(strobes - base, 2);
    check({s_addr, s_data}, {8'h06, wd});
    base = strobes;
    host.xfer(8'h12, 16'h0000, rd);
    tick(6);
    check(rd, {8'h12 ^ 8'h3c, 8'h13 ^ 8'h3c});
    check(strobes - base, 0);
    $display("serial test done");
  endtask
  task blocked;
    int base;
    power_ok = 1'b0;
    tick(5);
    base = strobes;
    host.xfer(8'h85, 16'h1234, rd);
    tick(6);
    check(strobes - base, 0);
    power_cycle(1'b0, RST_D);
    $display("blocked test done");
  endtask
  initial begin
    {failures, checks_done} = '0;
    {power_ok, resetn} = 2'h2;
    {osc_disabled, button, wave_enable, irq_enable, irq_request, three_wire} = '0;
    wave_rate = 2'h0;
    tick(6);
    resetn = 1'b1;
    power_cycle(1'b0, RST_D);
    power_cycle(1'b1, RST_D + OSC_D);
    button_press;
    wave_rates;
    serial(1'b0);
    serial(1'b1);
    blocked;
    results;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    results;
  end
endmodule
